/* File: rtl/mseq_pkg.sv */
// Operation
// [RQ1] shared bus sixteen bits, three-state only
// [RQ2] one bus driver per cycle at most
// [RQ3] no source selected means bus floats
// [RQ4] sequencer makes the system timing pulse
// [RQ5] decode drive and accept strobes per subsystem
// [RQ6] forty-bit register holds executing microinstruction
// [RQ7] control store 4096 words of forty bits
// [RQ8] next address: call, return or opcode table
// [RQ9] external inputs halt or single-step clocks
// [RQ10] interrupts taken only at opcode start
// [RQ11] interrupt diverts to prioritised handler entry
// [RQ12] run opcode sequence, then fetch next opcode
// [RQ13] arithmetic unit control bits issued
// [RQ14] driver enables one-hot, none during reset
// [RQ15] register loads on sequencer clock, pipelined
// [RQ16] slow bit stretches cycle to 225 ns
// [RQ17] busy memory interface stalls clock generation
// [RQ18] system clock only for formats with arithmetic control
package mseq_pkg;
  // clock and cycle timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int NORM_CYCLE_NS = 150;
  localparam int SLOW_CYCLE_NS = 225;
  localparam int NORM_CYC = (NORM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_CYC = (SLOW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] NORM_LAST = 5'(NORM_CYC - 1);
  localparam logic [4:0] SLOW_LAST = 5'(SLOW_CYC - 1);
  // widths
  localparam int BUS_W = 16;
  localparam int MI_W = 40;
  localparam int ADDR_W = 12;
  localparam int ALU_W = 20;
  localparam int SEL_N = 15;
  localparam int STK_N = 4;
  localparam int IRQ_N = 4;
  // microinstruction field positions
  localparam int F_DST_LSB = 0;
  localparam int F_SRC_LSB = 4;
  localparam int F_CONST_LSB = 0;
  localparam int F_ALU_LSB = 8;
  localparam int F_JADDR_LSB = 8;
  localparam int F_COND_LSB = 20;
  localparam int F_NAC_LSB = 34;
  localparam int F_SLOW_BIT = 37;
  localparam int F_FMT_LSB = 38;
  // formats
  localparam logic [1:0] FMT_I = 2'h0;
  localparam logic [1:0] FMT_II = 2'h1;
  localparam logic [1:0] FMT_III = 2'h2;
  // next address commands
  localparam logic [2:0] NAC_CONT = 3'h0;
  localparam logic [2:0] NAC_JUMP = 3'h1;
  localparam logic [2:0] NAC_CALL = 3'h2;
  localparam logic [2:0] NAC_RET = 3'h3;
  localparam logic [2:0] NAC_MAP = 3'h4;
  // bus select codes, zero means none
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_IFU = 4'h1;
  localparam logic [3:0] SEL_DPORT = 4'h2;
  localparam logic [3:0] SEL_ALU = 4'h3;
  // opcode map page and interrupt entry base
  localparam logic [3:0] MAP_PAGE = 4'h1;
  localparam logic [ADDR_W-1:0] INT_VEC_BASE = 12'hFF0;
  // reset values
  localparam logic [MI_W-1:0] MIR_RST = 40'h00_0000_0000;
  localparam logic [ADDR_W-1:0] UPC_RST = 12'h000;
endpackage

/* File: rtl/mseq_top.sv */
`timescale 1ns/100ps
module mseq_top
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // control store port
  output logic [11:0] cs_addr_out,
  input wire logic [39:0] cs_data_in,
  // opcode from the instruction fetch unit
  input wire logic [7:0] opcode_in,
  output logic opcode_take_out,
  // branch conditions and memory interface busy flags
  input wire logic [7:0] cond_in,
  input wire logic [1:0] mem_busy_in,
  // diagnostic clock control
  input wire logic halt_in,
  input wire logic step_in,
  // interrupt requests, bit 0 highest priority
  input wire logic [3:0] irq_in,
  output logic int_ack_out,
  output logic [1:0] int_id_out,
  // timing pulses
  output logic sequencer_clock_out,
  output logic processor_sync_clock_out,
  // bus control
  output logic [14:0] src_en_out,
  output logic [14:0] dst_en_out,
  output logic [19:0] alu_ctrl_out,
  output logic [15:0] bus_data_out,
  output logic bus_oe_n_out,
  output logic [39:0] micro_instruction_register_out
);

  typedef struct packed {
    logic [4:0] cnt;
    logic [39:0] micro_instruction_register;
    logic [11:0] upc;
    logic [1:0] sp;
    logic [3:0][11:0] stk;
    logic step_pend;
    logic seq_clk;
    logic proc_clk;
    logic [14:0] src_en;
    logic [14:0] dst_en;
    logic [19:0] alu;
    logic [15:0] bus;
    logic oe_n;
    logic op_take;
    logic int_ack;
    logic [1:0] int_id;
  } mseq_state_t;

  mseq_state_t s_q;
  mseq_state_t s_d;

  // fields of the executing word
  logic [1:0] cur_fmt;
  logic [3:0] cur_src;
  logic [3:0] cur_dst;
  // fields of the word arriving from the control store
  logic [1:0] new_fmt;
  logic [2:0] new_nac;
  logic [3:0] new_src;
  logic [3:0] new_dst;
  logic [3:0] new_cond;
  logic [11:0] new_jaddr;
  logic [4:0] last_cnt;
  logic stall;
  logic may_run;
  logic fire;
  logic cond_ok;
  logic irq_any;
  logic [1:0] irq_sel;
  logic [11:0] upc_inc;

  assign cur_fmt = s_q.micro_instruction_register[mseq_pkg::F_FMT_LSB +: 2];
  assign cur_src = s_q.micro_instruction_register[mseq_pkg::F_SRC_LSB +: 4];
  assign cur_dst = s_q.micro_instruction_register[mseq_pkg::F_DST_LSB +: 4];
  assign new_fmt = cs_data_in[mseq_pkg::F_FMT_LSB +: 2];
  assign new_nac = cs_data_in[mseq_pkg::F_NAC_LSB +: 3];
  assign new_src = cs_data_in[mseq_pkg::F_SRC_LSB +: 4];
  assign new_dst = cs_data_in[mseq_pkg::F_DST_LSB +: 4];
  assign new_cond = cs_data_in[mseq_pkg::F_COND_LSB +: 4];
  assign new_jaddr = cs_data_in[mseq_pkg::F_JADDR_LSB +: mseq_pkg::ADDR_W];
  assign upc_inc = s_q.upc + 12'h001;

  // cycle length comes from the word now executing
  // [RQ16] slow cycle select
  assign last_cnt = s_q.micro_instruction_register[mseq_pkg::F_SLOW_BIT] ? mseq_pkg::SLOW_LAST : mseq_pkg::NORM_LAST;

  // [RQ17] memory busy stall
  always_comb
  begin
    stall = 1'b0;
    if (cur_fmt == mseq_pkg::FMT_I)
    begin
      if ((cur_src == mseq_pkg::SEL_IFU || cur_dst == mseq_pkg::SEL_IFU) && mem_busy_in[0])
        stall = 1'b1;
      if ((cur_src == mseq_pkg::SEL_DPORT || cur_dst == mseq_pkg::SEL_DPORT) && mem_busy_in[1])
        stall = 1'b1;
    end
  end

  // [RQ9] halt and single step
  assign may_run = !halt_in || s_q.step_pend;
  // [RQ15] one clock event per interval
  assign fire = (s_q.cnt == last_cnt) && !stall && may_run;

  // condition select: low bits pick a line, top bit inverts
  assign cond_ok = cond_in[new_cond[2:0]] ^ new_cond[3];

  // [RQ11] fixed priority, lowest index wins
  always_comb
  begin
    irq_any = |irq_in;
    irq_sel = 2'h0;
    for (int i = mseq_pkg::IRQ_N - 1; i >= 0; i--)
    begin
      if (irq_in[i])
        irq_sel = 2'(i);
    end
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.seq_clk = 1'b0;
    s_d.proc_clk = 1'b0;
    s_d.op_take = 1'b0;
    s_d.int_ack = 1'b0;
    // a step request arriving with the consuming edge is kept
    s_d.step_pend = step_in || (s_q.step_pend && !(fire && halt_in));
    if (s_q.cnt != last_cnt)
      s_d.cnt = s_q.cnt + 5'h01;
    if (fire)
    begin
      s_d.cnt = 5'h00;
      // [RQ4] sequencer and system pulses
      s_d.seq_clk = 1'b1;
      // [RQ18] system clock gated by format
      s_d.proc_clk = (cur_fmt != mseq_pkg::FMT_III);
      // [RQ6] load holding register
      // [RQ7] word read at the fetched address
      s_d.micro_instruction_register = cs_data_in;
      // [RQ13] arithmetic control field
      s_d.alu = (new_fmt == mseq_pkg::FMT_III) ? 20'h0_0000 :
        cs_data_in[mseq_pkg::F_ALU_LSB +: mseq_pkg::ALU_W];
      // [RQ5] drive and accept strobes
      // [RQ14] one-hot enables
      s_d.src_en = 15'h0000;
      s_d.dst_en = 15'h0000;
      s_d.oe_n = 1'b1;
      s_d.bus = 16'h0000;
      if (new_fmt == mseq_pkg::FMT_I)
      begin
        // [RQ3] code zero selects no driver
        if (new_src != mseq_pkg::SEL_NONE)
          s_d.src_en[new_src - 4'h1] = 1'b1;
        if (new_dst != mseq_pkg::SEL_NONE)
          s_d.dst_en[new_dst - 4'h1] = 1'b1;
      end
      else if (new_fmt == mseq_pkg::FMT_II)
      begin
        // [RQ2] sequencer is sole driver of its constant
        s_d.oe_n = 1'b0;
        s_d.bus = {8'h00, cs_data_in[mseq_pkg::F_CONST_LSB +: 8]};
        s_d.dst_en[mseq_pkg::SEL_ALU - 4'h1] = 1'b1;
      end
      // [RQ8] next address selection
      s_d.upc = upc_inc;
      case (new_nac)
        mseq_pkg::NAC_CONT:
          s_d.upc = upc_inc;
        mseq_pkg::NAC_JUMP:
          if (cond_ok)
            s_d.upc = new_jaddr;
        mseq_pkg::NAC_CALL:
          if (cond_ok)
          begin
            s_d.stk[s_q.sp] = upc_inc;
            s_d.sp = s_q.sp + 2'h1;
            s_d.upc = new_jaddr;
          end
        mseq_pkg::NAC_RET:
        begin
          s_d.sp = s_q.sp - 2'h1;
          s_d.upc = s_q.stk[s_q.sp - 2'h1];
        end
        mseq_pkg::NAC_MAP:
          // [RQ10] interrupts checked at opcode start
          if (irq_any)
          begin
            s_d.upc = mseq_pkg::INT_VEC_BASE + {10'h000, irq_sel};
            s_d.int_ack = 1'b1;
            s_d.int_id = irq_sel;
          end
          else
          begin
            // [RQ12] start sequence of next opcode
            s_d.upc = {mseq_pkg::MAP_PAGE, opcode_in};
            s_d.op_take = 1'b1;
          end
        default:
          s_d.upc = upc_inc;
      endcase
    end
  end

  // state register; reset leaves every driver off
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s_q.cnt <= 5'h00;
      s_q.micro_instruction_register <= mseq_pkg::MIR_RST;
      s_q.upc <= mseq_pkg::UPC_RST;
      s_q.sp <= 2'h0;
      s_q.stk <= 48'h0000_0000_0000;
      s_q.step_pend <= 1'b0;
      s_q.seq_clk <= 1'b0;
      s_q.proc_clk <= 1'b0;
      s_q.src_en <= 15'h0000;
      s_q.dst_en <= 15'h0000;
      s_q.alu <= 20'h0_0000;
      s_q.bus <= 16'h0000;
      s_q.oe_n <= 1'b1;
      s_q.op_take <= 1'b0;
      s_q.int_ack <= 1'b0;
      s_q.int_id <= 2'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  // [RQ1] bus as data plus enable, no tri-state here
  assign cs_addr_out = s_q.upc;
  assign opcode_take_out = s_q.op_take;
  assign int_ack_out = s_q.int_ack;
  assign int_id_out = s_q.int_id;
  assign sequencer_clock_out = s_q.seq_clk;
  assign processor_sync_clock_out = s_q.proc_clk;
  assign src_en_out = s_q.src_en;
  assign dst_en_out = s_q.dst_en;
  assign alu_ctrl_out = s_q.alu;
  assign bus_data_out = s_q.bus;
  assign bus_oe_n_out = s_q.oe_n;
  assign micro_instruction_register_out = s_q.micro_instruction_register;

endmodule // mseq_top

/* File: bench/mseq_top_properties.sv */
`timescale 1ns/100ps
module mseq_top_properties
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [1:0] mem_busy_in,
  input wire logic int_ack_out,
  input wire logic sequencer_clock_out,
  input wire logic processor_sync_clock_out,
  input wire logic [14:0] src_en_out,
  input wire logic [14:0] dst_en_out,
  input wire logic [15:0] bus_data_out,
  input wire logic bus_oe_n_out,
  input wire logic [39:0] micro_instruction_register_out,
  input wire logic [11:0] cs_addr_out
);
  wire logic [39:0] mi = micro_instruction_register_out;
  logic [5:0] gap_q;
  // cycles since last pulse; starts saturated so the first pulse is not judged
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    if (sys_rst_in)
      gap_q <= 6'h3F;
    else if (sequencer_clock_out)
      gap_q <= 6'h00;
    else if (gap_q != 6'h3F)
      gap_q <= gap_q + 6'h01;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_drv_onehot: assert property ($onehot0({src_en_out, !bus_oe_n_out}))
    else $error("two bus drivers enabled");
  chk_gap_normal: assert property (sequencer_clock_out |-> gap_q >= 6'h12)
    else $error("microcycle shorter than normal");
  chk_gap_slow: assert property (sequencer_clock_out && $past(mi[37]) |-> gap_q >= 6'h1C)
    else $error("slow microcycle not stretched");
  chk_const_drive: assert property (mi[39:38] == mseq_pkg::FMT_II |-> !bus_oe_n_out
    && bus_data_out == {8'h00, mi[7:0]} && dst_en_out == 15'h0004) else $error("constant bad");
  chk_jump_quiet: assert property (mi[39:38] == mseq_pkg::FMT_III |-> bus_oe_n_out
    && src_en_out == 15'h0000 && dst_en_out == 15'h0000) else $error("jump word drives bus");
  chk_sync_format: assert property (processor_sync_clock_out ==
    (sequencer_clock_out && $past(mi[39:38]) != mseq_pkg::FMT_III)) else $error("sync pulse bad");
  chk_busy_stall: assert property (mem_busy_in[0] && mi[39:38] == mseq_pkg::FMT_I
    && mi[7:4] == 4'h1 |=> !sequencer_clock_out) else $error("clock ran while busy");
  chk_dport_stall: assert property (mem_busy_in[1] && mi[39:38] == mseq_pkg::FMT_I
    && mi[3:0] == 4'h2 |=> !sequencer_clock_out) else $error("clock ran while port busy");
  chk_irq_boundary: assert property (int_ack_out |-> sequencer_clock_out
    && mi[36:34] == mseq_pkg::NAC_MAP && cs_addr_out[11:4] == 8'hFF) else $error("irq mid opcode");
  chk_addr_hold: assert property (!sequencer_clock_out |-> $stable(cs_addr_out))
    else $error("address moved between pulses");
  cover property (int_ack_out);
  cover property (sequencer_clock_out && $past(mi[37]));
  cover property (!bus_oe_n_out);
  cover property (mem_busy_in[1] && !sequencer_clock_out);
endmodule // mseq_top_properties

/* File: bench/mseq_far.sv */
`timescale 1ns/100ps
module mseq_far
(
  input wire logic [11:0] addr_in,
  input wire logic [14:0] src_en_in,
  input wire logic [15:0] seq_data_in,
  input wire logic seq_oe_n_in,
  output logic [39:0] word_out,
  output wire logic [15:0] bus_out
);
  always_comb
    case (addr_in)
      12'h000: word_out = 40'h00_0ABC_D032;
      12'h001: word_out = 40'h40_0000_005A;
      12'h002: word_out = 40'h88_0000_1000;
      12'h010: word_out = 40'h0C_0000_0010;
      12'h003: word_out = 40'h30_0000_0000;
      default: word_out = 40'h84_00F0_0000; // back to zero while cond_in[7] is low
    endcase
  // three-state drivers; a clash would show as x on the bus
  assign bus_out = seq_oe_n_in ? 16'hZZZZ : seq_data_in;
  assign bus_out = src_en_in[2] ? 16'hC3A5 : 16'hZZZZ;
endmodule // mseq_far

/* File: bench/mseq_top_test.sv */
`timescale 1ns/100ps
module mseq_top_test;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] opcode_in = 8'hA5;
  logic [7:0] cond_in = 8'h01;
  logic [1:0] mem_busy_in = 2'h0;
  logic halt_in = 1'b0;
  logic step_in = 1'b0;
  logic [3:0] irq_in = 4'h0;
  logic [39:0] cs_data_in, micro_instruction_register_out;
  logic [11:0] cs_addr_out;
  logic opcode_take_out, int_ack_out, sequencer_clock_out, processor_sync_clock_out;
  logic bus_oe_n_out;
  logic [1:0] int_id_out;
  logic [14:0] src_en_out, dst_en_out;
  logic [19:0] alu_ctrl_out;
  logic [15:0] bus_data_out;
  wire [15:0] bus;
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  mseq_top dut (.sys_clk_in, .sys_rst_in, .cs_addr_out, .cs_data_in, .opcode_in, .opcode_take_out,
    .cond_in, .mem_busy_in, .halt_in, .step_in, .irq_in, .int_ack_out, .int_id_out,
    .sequencer_clock_out, .processor_sync_clock_out, .src_en_out, .dst_en_out, .alu_ctrl_out,
    .bus_data_out, .bus_oe_n_out, .micro_instruction_register_out);
  mseq_far far (.addr_in(cs_addr_out), .src_en_in(src_en_out), .seq_data_in(bus_data_out),
    .seq_oe_n_in(bus_oe_n_out), .word_out(cs_data_in), .bus_out(bus));
  initial forever #4 sys_clk_in = ~sys_clk_in;
  // cut a hung run short and count it as a mismatch
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
      test_done(1);
  end
  task check(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // next sequencer pulse within lim cycles; n is the wait
  task pulse(input int lim);
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    while (sequencer_clock_out !== 1'b1 && n < lim);
  endtask
  task t_walk;
    // state is unknown until the first edge seen under reset
    @(posedge sys_clk_in);
    #1;
    check({bus_oe_n_out, src_en_out, dst_en_out}, {1'b1, 15'h0000, 15'h0000});
    check({sequencer_clock_out, cs_addr_out}, {1'b0, 12'h000});
    repeat (15) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    pulse(80);
    check({n, micro_instruction_register_out}, {32'h13, 40'h00_0ABC_D032});
    check({alu_ctrl_out, src_en_out, dst_en_out}, {20'hABCD0, 15'h0004, 15'h0002});
    check({processor_sync_clock_out, bus}, {1'b1, 16'hC3A5});
    // a busy data port under a destination-2 word holds the clocks and the driver
    mem_busy_in = 2'h2;
    pulse(30);
    check({sequencer_clock_out, bus}, {1'b0, 16'hC3A5});
    mem_busy_in = 2'h0;
    pulse(80);
    check({cs_addr_out, bus_oe_n_out, bus}, {12'h002, 1'b0, 16'h005A});
    pulse(80);
    check({cs_addr_out, src_en_out, bus}, {12'h010, 15'h0000, 16'hZZZZ});
    pulse(80);
    check({cs_addr_out, processor_sync_clock_out}, {12'h003, 1'b0});
    // a busy fetch unit under a source-1 word must freeze the clocks
    mem_busy_in = 2'h1;
    pulse(40);
    check(sequencer_clock_out, 1'b0);
    mem_busy_in = 2'h0;
    pulse(80);
    check({n, cs_addr_out, opcode_take_out}, {32'h1, 12'h1A5, 1'b1});
    pulse(80);
    check({n, cs_addr_out}, {32'h1D, 12'h000});
  endtask
  // two requests pending: lower bit wins, and only at the map word
  task t_irq;
    irq_in = 4'h6;
    repeat (4) pulse(80);
    check({cs_addr_out, int_ack_out}, {12'h003, 1'b0});
    pulse(80);
    check({cs_addr_out, int_ack_out, int_id_out, opcode_take_out}, {12'hFF1, 3'h5, 1'b0});
    irq_in = 4'h0;
    pulse(80);
    check(cs_addr_out, 12'h000);
  endtask
  task t_halt;
    halt_in = 1'b1;
    opcode_in = 8'h3C;
    pulse(60);
    check(sequencer_clock_out, 1'b0);
    step_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    step_in = 1'b0;
    pulse(5);
    check(sequencer_clock_out, 1'b1);
    pulse(40);
    check(sequencer_clock_out, 1'b0);
    halt_in = 1'b0;
    repeat (4) pulse(80);
    check(cs_addr_out, 12'h13C);
  endtask
  task test_done(input int extra);
    fail_count += extra;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    t_walk();
    t_irq();
    t_halt();
    test_done(0);
  end
endmodule // mseq_top_test
bind mseq_top mseq_top_properties u_prop (.sys_clk_in, .sys_rst_in, .mem_busy_in, .int_ack_out,
  .sequencer_clock_out, .processor_sync_clock_out, .src_en_out, .dst_en_out, .bus_data_out,
  .bus_oe_n_out, .micro_instruction_register_out, .cs_addr_out);
